// ==== smfe_pkg.sv ====
// Constants, carrier types and states for the secure memory serial front end
// Operation
// - Each answer bit on the data pin lasts 372 periods of the clock pin.
// - In synchronous mode host data bits are sampled on the rising edge of the serial clock.
// - In synchronous mode read data bits are launched on the falling edge of the serial clock.
// - Releasing the reset pin sends the 64-bit answer register as a sequence of reset-answer characters.
// - The reset pad is pulled high inside, so an unconnected pad leaves the device in synchronous mode.
// - No reset-answer characters are sent while the device works in synchronous mode.
// - The data pin is shared in both modes and is only ever pulled low, otherwise released.
// - Up to 15 devices share the two-wire bus and each answers only its own address.
// - The 128-byte user memory is four 32-byte zones with their own access rights.
// - Writes take a single byte or a page of up to 16 bytes, followed by internally timed programming.
// - Eight password sets of two 24-bit passwords are held for access checks.
// - Data changes only while the serial clock is low; a change while high is a start or stop.
// - A data fall while the serial clock is high is a start, which opens every command.
package smfe_pkg;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          US_PER_S    = 1_000_000;
  localparam int          ETU_CLKS    = 372;
  localparam int          T_WR_US     = 5000;
  localparam int          WR_CYC      = T_WR_US * (CLK_HZ / US_PER_S);
  localparam int          ATR_BYTES   = 8;
  localparam int          MEM_BYTES   = 128;
  localparam int          ZONE_BYTES  = 32;
  localparam int          PAGE_BYTES  = 16;
  localparam int          PW_SETS     = 8;
  localparam int          PW_PER_SET  = 2;
  localparam int          PW_BITS     = 24;
  localparam logic [63:0] ATR_DEFAULT = 64'h3b00_0000_0000_0000;
  localparam logic [23:0] PW_DEFAULT  = 24'h000000;
  localparam logic [7:0]  RD_LOCKED   = 8'hff;
  localparam logic [3:0]  NO_ADDR     = 4'h0;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  localparam logic [3:0]  ACK_SLOT    = 4'h8;
  localparam logic [3:0]  DATA_LAST   = 4'h8;
  localparam logic [3:0]  PAR_IDX     = 4'h9;
  localparam logic [3:0]  CHAR_LAST   = 4'hb;
  localparam int          CMD_ADDR_HI = 7;
  localparam int          CMD_ADDR_LO = 4;
  localparam int          CMD_RW_BIT  = 0;
  localparam logic [1:0]  STRAP_LAST  = 2'h3;

  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       rst;
    logic [3:0] addr;
  } smfe_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_ADDR  = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_SKIP  = 3'h4
  } smfe_state_t;
endpackage

// ==== smfe_top.sv ====
// Pin-level front end: reset-answer sender, two-wire slave, user memory, passwords
module smfe_top
  import smfe_pkg::*;
#(
  parameter int           BIT_PERIOD_UNIT       = ETU_CLKS,
  parameter int           WR_CYCLES = WR_CYC,
  parameter logic [63:0]  ATR_VAL   = ATR_DEFAULT,
  parameter logic [23:0]  PW_INIT   = PW_DEFAULT
)(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        link_clk_i,
  input  wire logic        sda_i,
  input  wire logic        rst_pad_i,
  input  wire logic        rst_pad_drv_i,
  input  wire logic [3:0]  dev_addr_i,
  input  wire logic [3:0]  zone_rd_ok_i,
  input  wire logic [3:0]  zone_wr_ok_i,
  input  wire logic        pw_wr_i,
  input  wire logic        pw_chk_i,
  input  wire logic [2:0]  pw_set_i,
  input  wire logic        pw_idx_i,
  input  wire logic [23:0] pw_val_i,
  output logic             sda_o,
  output logic             sda_oe_b_o,
  output logic             async_mode_o,
  output logic             wr_busy_o,
  output logic             pw_ok_o
);
  localparam int ADDR_W = $clog2(MEM_BYTES);
  localparam int PG_W   = $clog2(PAGE_BYTES);
  localparam int ZN_W   = $clog2(ZONE_BYTES);
  localparam int ETU_W  = $clog2(BIT_PERIOD_UNIT);
  localparam int WR_W   = $clog2(WR_CYCLES);

  function automatic logic [1:0] zone_of(input logic [ADDR_W-1:0] a);
    return 2'(a >> ZN_W);
  endfunction

  function automatic logic atr_low(input logic [7:0] b, input logic [3:0] idx);
    logic [3:0] di;
    di = idx - 4'h1;
    if (idx == 4'h0)
      return 1'b1;
    else if (idx <= DATA_LAST)
      return ~b[di[2:0]];
    else if (idx == PAR_IDX)
      return ~(^b);
    else
      return 1'b0;
  endfunction

  // Pin synchronisers
  smfe_pins_t pin_raw;
  smfe_pins_t pin_s1_r;
  smfe_pins_t pin_s2_r;
  smfe_pins_t pin_s3_r;
  assign pin_raw.scl  = link_clk_i;
  assign pin_raw.sda  = sda_i;
  assign pin_raw.rst  = rst_pad_drv_i ? rst_pad_i : 1'b1;
  assign pin_raw.addr = dev_addr_i;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1_r <= '{scl: 1'b1, sda: 1'b1, rst: 1'b1, addr: NO_ADDR};
      pin_s2_r <= '{scl: 1'b1, sda: 1'b1, rst: 1'b1, addr: NO_ADDR};
      pin_s3_r <= '{scl: 1'b1, sda: 1'b1, rst: 1'b1, addr: NO_ADDR};
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire logic scl_rise = pin_s2_r.scl & ~pin_s3_r.scl;
  wire logic scl_fall = ~pin_s2_r.scl & pin_s3_r.scl;
  wire logic sda_s    = pin_s2_r.sda;
  wire logic rst_s    = pin_s2_r.rst;
  wire logic rst_rise = pin_s2_r.rst & ~pin_s3_r.rst;
  wire logic scl_hi   = pin_s2_r.scl & pin_s3_r.scl;
  wire logic start    = scl_hi & ~pin_s2_r.sda & pin_s3_r.sda;
  wire logic stop     = scl_hi & pin_s2_r.sda & ~pin_s3_r.sda;

  // Strap capture and mode
  logic [3:0] dev_addr_r;
  logic [1:0] strap_cnt_r;
  logic       async_mode_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dev_addr_r   <= NO_ADDR;
      strap_cnt_r  <= '0;
      async_mode_r <= 1'b0;
    end
    else
    begin
      // Strap taken once the synchroniser holds real pin values
      if (strap_cnt_r != STRAP_LAST)
      begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        dev_addr_r  <= pin_s2_r.addr;
      end
      if (!rst_s)
        async_mode_r <= 1'b1;
    end
  end

  // Reset-answer sender
  logic [ETU_W-1:0] etu_cnt_r;
  logic [2:0]       atr_byte_r;
  logic [3:0]       atr_bit_r;
  logic             atr_busy_r;
  logic             atr_drv_r;
  wire logic        etu_wrap = scl_rise & (etu_cnt_r == ETU_W'(BIT_PERIOD_UNIT - 1));
  wire logic [7:0]  atr_cur  = ATR_VAL[(ATR_BYTES - 1 - int'(atr_byte_r)) * 8 +: 8];
  wire logic [3:0]  atr_nbit = atr_bit_r + 4'h1;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      etu_cnt_r  <= '0;
      atr_byte_r <= '0;
      atr_bit_r  <= '0;
      atr_busy_r <= 1'b0;
      atr_drv_r  <= 1'b0;
    end
    else if (!rst_s)
    begin
      atr_busy_r <= 1'b0;
      atr_drv_r  <= 1'b0;
    end
    else if (rst_rise && async_mode_r)
    begin
      atr_busy_r <= 1'b1;
      atr_byte_r <= '0;
      atr_bit_r  <= '0;
      etu_cnt_r  <= '0;
      atr_drv_r  <= 1'b1;
    end
    else if (atr_busy_r && scl_rise)
    begin
      if (etu_wrap)
      begin
        etu_cnt_r <= '0;
        if (atr_bit_r == CHAR_LAST)
        begin
          atr_bit_r  <= '0;
          atr_byte_r <= atr_byte_r + 3'h1;
          atr_busy_r <= (atr_byte_r != 3'(ATR_BYTES - 1));
          atr_drv_r  <= (atr_byte_r != 3'(ATR_BYTES - 1));
        end
        else
        begin
          atr_bit_r <= atr_nbit;
          atr_drv_r <= atr_low(atr_cur, atr_nbit);
        end
      end
      else
        etu_cnt_r <= etu_cnt_r + ETU_W'(1);
    end
  end

  // Two-wire slave
  smfe_state_t       st_r;
  logic [3:0]        cnt_r;
  logic [7:0]        sh_r;
  logic [7:0]        out_r;
  logic [ADDR_W-1:0] ptr_r;
  logic              rw_r;
  logic              sync_drv_r;
  logic              wr_busy_r;
  logic [7:0]        mem_r [MEM_BYTES];

  wire logic active   = (st_r != ST_IDLE) && (st_r != ST_SKIP);
  wire logic matched  = (sh_r[CMD_ADDR_HI:CMD_ADDR_LO] == dev_addr_r) && (dev_addr_r != NO_ADDR)
                        && !wr_busy_r;
  wire logic [7:0] rd_byte = zone_rd_ok_i[zone_of(ptr_r)] ? mem_r[ptr_r] : RD_LOCKED;
  wire logic byte_end = scl_fall & active & (cnt_r == LAST_BIT);
  wire logic ack_end  = scl_fall & active & (cnt_r == ACK_SLOT);
  wire logic to_read  = (st_r == ST_RDATA) || ((st_r == ST_CMD) && rw_r);
  wire logic pg_we    = byte_end & (st_r == ST_WDATA);
  wire logic [ADDR_W-1:0] ptr_pg = {ptr_r[ADDR_W-1:PG_W], ptr_r[PG_W-1:0] + PG_W'(1)};

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r       <= ST_IDLE;
      cnt_r      <= '0;
      sh_r       <= '0;
      out_r      <= '0;
      ptr_r      <= '0;
      rw_r       <= 1'b0;
      sync_drv_r <= 1'b0;
    end
    else if (async_mode_r || stop)
    begin
      st_r       <= ST_IDLE;
      sync_drv_r <= 1'b0;
    end
    else if (start)
    begin
      // First fall after start wraps the count to zero
      st_r       <= ST_CMD;
      cnt_r      <= '1;
      sync_drv_r <= 1'b0;
    end
    else if (scl_rise && active)
    begin
      if (cnt_r != ACK_SLOT)
        sh_r <= {sh_r[6:0], sda_s};
      else if (st_r == ST_RDATA && sda_s)
        st_r <= ST_SKIP;
    end
    else if (byte_end)
    begin
      cnt_r <= ACK_SLOT;
      case (st_r)
        ST_CMD:
        begin
          rw_r       <= sh_r[CMD_RW_BIT];
          sync_drv_r <= matched;
          if (!matched)
            st_r <= ST_SKIP;
        end
        ST_ADDR:
        begin
          ptr_r      <= sh_r[ADDR_W-1:0];
          sync_drv_r <= 1'b1;
        end
        ST_WDATA:
        begin
          ptr_r      <= ptr_pg;
          sync_drv_r <= 1'b1;
        end
        default: sync_drv_r <= 1'b0;
      endcase
    end
    else if (ack_end)
    begin
      cnt_r <= '0;
      if (to_read)
      begin
        st_r       <= ST_RDATA;
        out_r      <= {rd_byte[6:0], 1'b1};
        sync_drv_r <= ~rd_byte[7];
        ptr_r      <= ptr_r + ADDR_W'(1);
      end
      else
      begin
        st_r       <= (st_r == ST_CMD) ? ST_ADDR : ST_WDATA;
        sync_drv_r <= 1'b0;
      end
    end
    else if (scl_fall && active)
    begin
      cnt_r <= cnt_r + 4'h1;
      if (st_r == ST_RDATA)
      begin
        sync_drv_r <= ~out_r[7];
        out_r      <= {out_r[6:0], 1'b1};
      end
    end
  end

  // Page buffer and self-timed programming
  logic [7:0]            pg_data_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pg_vld_r;
  logic [ADDR_W-PG_W-1:0] pg_base_r;
  logic [WR_W-1:0]       wr_cnt_r;
  wire logic wr_go   = stop & !async_mode_r & (st_r == ST_WDATA) & (|pg_vld_r) & !wr_busy_r;
  wire logic wr_done = wr_busy_r & (wr_cnt_r == WR_W'(WR_CYCLES - 1));

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pg_vld_r  <= '0;
      pg_base_r <= '0;
      wr_cnt_r  <= '0;
      wr_busy_r <= 1'b0;
    end
    else if (wr_go)
    begin
      wr_busy_r <= 1'b1;
      wr_cnt_r  <= '0;
      pg_base_r <= ptr_r[ADDR_W-1:PG_W];
    end
    else if (wr_busy_r)
    begin
      wr_cnt_r <= wr_cnt_r + WR_W'(1);
      if (wr_done)
      begin
        wr_busy_r <= 1'b0;
        pg_vld_r  <= '0;
      end
    end
    else if (start)
      pg_vld_r <= '0;
    else if (pg_we)
      pg_vld_r[ptr_r[PG_W-1:0]] <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (pg_we && !wr_busy_r)
      pg_data_r[ptr_r[PG_W-1:0]] <= sh_r;
  end

  genvar gi;
  generate
    for (gi = 0; gi < MEM_BYTES; gi++)
    begin : g_commit
      localparam logic [ADDR_W-1:0] DST = ADDR_W'(gi);
      wire logic wr_hit = wr_done && (pg_base_r == DST[ADDR_W-1:PG_W]) && pg_vld_r[DST[PG_W-1:0]]
                          && zone_wr_ok_i[zone_of(DST)];
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mem_r[gi] <= '0;
        else if (wr_hit)
          mem_r[gi] <= pg_data_r[DST[PG_W-1:0]];
      end
    end
  endgenerate

  // Password store
  logic [PW_BITS-1:0] pw_r [PW_SETS][PW_PER_SET];
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pw_ok_o <= 1'b0;
      for (int s = 0; s < PW_SETS; s++)
        for (int k = 0; k < PW_PER_SET; k++)
          pw_r[s][k] <= PW_INIT;
    end
    else
    begin
      if (pw_wr_i)
        pw_r[pw_set_i][pw_idx_i] <= pw_val_i;
      if (pw_chk_i)
        pw_ok_o <= (pw_r[pw_set_i][pw_idx_i] == pw_val_i);
    end
  end

  // Open-drain pin and status outputs
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sda_o        <= 1'b0;
      sda_oe_b_o   <= 1'b1;
      async_mode_o <= 1'b0;
      wr_busy_o    <= 1'b0;
    end
    else
    begin
      sda_o        <= 1'b0;
      sda_oe_b_o   <= ~(sync_drv_r | atr_drv_r);
      async_mode_o <= async_mode_r;
      wr_busy_o    <= wr_busy_r;
    end
  end

  // Checks
  property p_etu_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($changed(atr_drv_r) && atr_busy_r && $past(atr_busy_r) && $past(rst_s)) |-> $past(etu_wrap);
  endproperty
  a_etu_len: assert property (p_etu_len) else $error("answer bit changed off a bit period edge");

  property p_sample_rise;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($changed(sh_r) && !$past(async_mode_r)) |-> $past(scl_rise);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("data shifted in without clock rise");

  property p_launch_fall;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($rose(sync_drv_r) && $past(st_r) == ST_RDATA) |-> $past(scl_fall);
  endproperty
  a_launch_fall: assert property (p_launch_fall) else $error("read bit launched without clock fall");

  property p_atr_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    ($fell(atr_busy_r) && rst_s) |-> ($past(atr_byte_r) == 3'(ATR_BYTES - 1) && $past(atr_bit_r) == CHAR_LAST);
  endproperty
  a_atr_len: assert property (p_atr_len) else $error("answer sequence ended early");

  property p_mode_pull;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(async_mode_r) |-> !$past(rst_s);
  endproperty
  a_mode_pull: assert property (p_mode_pull) else $error("async mode without reset pad low");

  property p_no_atr_sync;
    @(posedge clk_i) disable iff (!rst_b_i)
    !async_mode_r |-> (!atr_busy_r && !atr_drv_r);
  endproperty
  a_no_atr_sync: assert property (p_no_atr_sync) else $error("answer sent in synchronous mode");

  property p_drive_low;
    @(posedge clk_i) disable iff (!rst_b_i)
    (!sda_o) and (!sda_oe_b_o |-> $past(sync_drv_r | atr_drv_r));
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data pin driven high or without cause");

  property p_addr_ack;
    @(posedge clk_i) disable iff (!rst_b_i)
    (byte_end && st_r == ST_CMD && !async_mode_r && !stop && !start) |=> (sync_drv_r == $past(matched));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("ack does not follow address match");

  property p_wr_time;
    @(posedge clk_i) disable iff (!rst_b_i)
    (wr_busy_r && !wr_done) |=> wr_busy_r;
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("programming ended before its time");
endmodule

// ==== smfe_host.sv ====
// Host model: two-wire master and card reader on the shared clock and data pins
module smfe_host
  import smfe_pkg::*;
#(
  parameter int BIT_PERIOD_UNIT = ETU_CLKS
)(
  input  wire logic clk_i,
  input  wire logic sda_line_i,
  output logic      link_clk_o,
  output logic      sda_rel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_r;
  int   unstable_cnt;
  initial
  begin
    link_clk_o   = 1'b1;
    sda_rel_o    = 1'b1;
    run_r        = 1'b0;
    unstable_cnt = 0;
  end
  // Carrier runs only while run_r is set: the floating-pad check and the card answer
  always
  begin
    @(negedge clk_i);
    if (run_r)
    begin
      repeat (3) @(negedge clk_i);
      link_clk_o = ~link_clk_o;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic tw_start();
    sda_rel_o = 1'b1;
    tick(4);
    link_clk_o = 1'b1;
    tick(2);
    sda_rel_o = 1'b0;
    tick(2);
    link_clk_o = 1'b0;
    tick(1);
  endtask
  task automatic tw_stop();
    sda_rel_o = 1'b0;
    tick(2);
    link_clk_o = 1'b1;
    tick(2);
    sda_rel_o = 1'b1;
    tick(2);
  endtask
  // One bit: data set while clock low, read twice while clock high
  task automatic tw_bit(input logic b, output logic r);
    sda_rel_o = b;
    tick(5);
    link_clk_o = 1'b1;
    tick(2);
    r = sda_line_i;
    tick(2);
    if (sda_line_i !== r)
      unstable_cnt++;
    link_clk_o = 1'b0;
    tick(1);
  endtask
  task automatic tw_wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      tw_bit(b[i], r);
    tw_bit(1'b1, r);
    ack = (r === 1'b0);
  endtask
  task automatic tw_rbyte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      tw_bit(1'b1, r);
      b[i] = r;
    end
    tw_bit(~more, r);
  endtask
  // Samples 96 bit periods from the middle of the first start bit
  task automatic get_answer(output logic [95:0] cap, output logic seen);
    int n;
    n = 0;
    while (sda_line_i !== 1'b0 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    seen = (sda_line_i === 1'b0);
    repeat (BIT_PERIOD_UNIT / 2) @(posedge link_clk_o);
    for (int k = 0; k < 96; k++)
    begin
      cap[k] = sda_line_i;
      repeat (BIT_PERIOD_UNIT) @(posedge link_clk_o);
    end
  endtask
endmodule

// ==== tb_smfe_top.sv ====
// Self-checking bench for the secure memory serial front end
module tb_smfe_top
  import smfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          T_ETU   = 8;
  localparam int          T_WR    = 150;
  localparam logic [63:0] T_ATR   = 64'h3b6a_0012_c4f0_5e81;
  localparam logic [3:0]  MY_ADDR = 4'h5;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdat;
    logic [7:0] rexp;
  } smfe_row_t;
  smfe_row_t   rows [6] = '{'{7'h00, 8'ha5, 8'ha5}, '{7'h1f, 8'h3c, 8'h3c}, '{7'h20, 8'h81, 8'h81},
                            '{7'h45, 8'h5a, RD_LOCKED}, '{7'h60, 8'h77, 8'h00}, '{7'h7f, 8'he1, 8'h00}};
  logic        clk_i, rst_b_i, rst_pad_i, rst_pad_drv_i, pw_wr_i, pw_chk_i, pw_idx_i;
  logic        link_clk, sda_rel, sda_line, sda_o, sda_oe_b_o, async_mode_o, wr_busy_o, pw_ok_o;
  logic [3:0]  dev_addr_i, zone_rd_ok_i, zone_wr_ok_i;
  logic [2:0]  pw_set_i;
  logic [23:0] pw_val_i;
  logic [7:0]  q [16];
  logic [95:0] cap;
  logic        ack, seen;
  int          errors, cmp_count, n;

  assign sda_line = sda_rel & (sda_oe_b_o | sda_o);

  smfe_top #(.BIT_PERIOD_UNIT(T_ETU), .WR_CYCLES(T_WR), .ATR_VAL(T_ATR)) smfe_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk), .sda_i(sda_line),
    .rst_pad_i(rst_pad_i), .rst_pad_drv_i(rst_pad_drv_i), .dev_addr_i(dev_addr_i),
    .zone_rd_ok_i(zone_rd_ok_i), .zone_wr_ok_i(zone_wr_ok_i), .pw_wr_i(pw_wr_i),
    .pw_chk_i(pw_chk_i), .pw_set_i(pw_set_i), .pw_idx_i(pw_idx_i), .pw_val_i(pw_val_i),
    .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .async_mode_o(async_mode_o),
    .wr_busy_o(wr_busy_o), .pw_ok_o(pw_ok_o));
  smfe_host #(.BIT_PERIOD_UNIT(T_ETU)) smfe_host_inst (
    .clk_i(clk_i), .sda_line_i(sda_line), .link_clk_o(link_clk), .sda_rel_o(sda_rel));

  always #50 clk_i = ~clk_i;

  task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] strap);
    rst_b_i = 1'b0;
    dev_addr_i = strap;
    repeat (5) @(negedge clk_i);
    check("reset outputs", 4'b1000, {sda_oe_b_o, async_mode_o, wr_busy_o, pw_ok_o});
    rst_b_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask
  task automatic tw_cmd(input logic rd, input logic [3:0] a, output logic ok);
    smfe_host_inst.tw_start();
    smfe_host_inst.tw_wbyte({a, 3'h0, rd}, ok);
  endtask
  task automatic tw_write(input logic [6:0] a, input int cnt, input logic [7:0] base);
    logic ok;
    tw_cmd(1'b0, MY_ADDR, ok);
    check("write cmd ack", 1'b1, ok);
    smfe_host_inst.tw_wbyte({1'b0, a}, ok);
    check("address ack", 1'b1, ok);
    for (int i = 0; i < cnt; i++)
    begin
      smfe_host_inst.tw_wbyte(base + 8'(i), ok);
      check("data ack", 1'b1, ok);
    end
    smfe_host_inst.tw_stop();
  endtask
  task automatic tw_read(input logic [6:0] a, input int cnt, output logic [7:0] d [16]);
    logic ok;
    tw_cmd(1'b0, MY_ADDR, ok);
    smfe_host_inst.tw_wbyte({1'b0, a}, ok);
    tw_cmd(1'b1, MY_ADDR, ok);
    check("read cmd ack", 1'b1, ok);
    for (int i = 0; i < cnt; i++)
      smfe_host_inst.tw_rbyte(i < cnt - 1, d[i]);
    smfe_host_inst.tw_stop();
  endtask
  task automatic wait_busy(output int cnt);
    int w;
    cnt = 0;
    w = 0;
    while (wr_busy_o !== 1'b1 && w < 20)
    begin
      @(negedge clk_i);
      w++;
    end
    while (wr_busy_o === 1'b1 && cnt < 200)
    begin
      @(negedge clk_i);
      cnt++;
    end
  endtask
  task automatic pw_pulse(input logic chk, input logic [2:0] s, input logic i, input logic [23:0] v);
    pw_set_i = s;
    pw_idx_i = i;
    pw_val_i = v;
    pw_chk_i = chk;
    pw_wr_i = ~chk;
    @(negedge clk_i);
    pw_chk_i = 1'b0;
    pw_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  function automatic logic [95:0] frames(input logic [63:0] v);
    logic [7:0] b;
    frames = '0;
    for (int c = 0; c < 8; c++)
    begin
      b = v[63 - 8 * c -: 8];
      frames[12 * c +: 12] = {2'b11, ^b, b, 1'b0};
    end
  endfunction

  initial
  begin
    #5_000_000;
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial
  begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    rst_pad_i = 1'b0;
    rst_pad_drv_i = 1'b0;
    dev_addr_i = MY_ADDR;
    zone_rd_ok_i = 4'b1011;
    zone_wr_ok_i = 4'b0111;
    pw_wr_i = 1'b0;
    pw_chk_i = 1'b0;
    pw_set_i = 3'h0;
    pw_idx_i = 1'b0;
    pw_val_i = 24'h000000;
    errors = 0;
    cmp_count = 0;
    do_reset(MY_ADDR);
    // Floating pad with carrier running: no card answer
    smfe_host_inst.run_r = 1'b1;
    n = 0;
    repeat (300)
    begin
      @(negedge clk_i);
      n += int'(sda_line === 1'b0);
    end
    check("answer in sync mode", 0, n);
    check("floating pad mode", 1'b0, async_mode_o);
    smfe_host_inst.run_r = 1'b0;
    repeat (8) @(negedge clk_i);
    foreach (rows[i])
    begin
      tw_write(rows[i].addr, 1, rows[i].wdat);
      wait_busy(n);
      tw_read(rows[i].addr, 1, q);
      check("row data", rows[i].rexp, q[0]);
    end
    // Page of 17 bytes wraps onto its first slot
    tw_write(7'h30, 17, 8'h10);
    wait_busy(n);
    check("busy cycles", T_WR, n);
    tw_read(7'h30, 16, q);
    for (int i = 0; i < 16; i++)
      check("page data", (i == 0) ? 8'h20 : 8'h10 + 8'(i), q[i]);
    tw_write(7'h10, 1, 8'h99);
    tw_cmd(1'b0, MY_ADDR, ack);
    check("ack while busy", 1'b0, ack);
    smfe_host_inst.tw_stop();
    wait_busy(n);
    tw_cmd(1'b0, 4'h3, ack);
    check("foreign address ack", 1'b0, ack);
    smfe_host_inst.tw_stop();
    check("data moved while clock high", 0, smfe_host_inst.unstable_cnt);
    for (int s = 0; s < 8; s++)
      pw_pulse(1'b0, 3'(s), 1'b1, 24'ha50000 + 24'(s));
    for (int s = 0; s < 8; s++)
    begin
      pw_pulse(1'b1, 3'(s), 1'b1, 24'ha50000 + 24'(s));
      check("password match", 1'b1, pw_ok_o);
      pw_pulse(1'b1, 3'(s), 1'b0, 24'ha50000 + 24'(s));
      check("password other slot", 1'b0, pw_ok_o);
      pw_pulse(1'b1, 3'(s), 1'b0, 24'h000000);
      check("password reset value", 1'b1, pw_ok_o);
    end
    // Card mode: answer aborted by the pad, then sent whole
    rst_pad_drv_i = 1'b1;
    smfe_host_inst.run_r = 1'b1;
    repeat (10) @(negedge clk_i);
    check("card mode", 1'b1, async_mode_o);
    rst_pad_i = 1'b1;
    repeat (3 * T_ETU + T_ETU / 2) @(posedge link_clk);
    @(negedge clk_i);
    check("answer pulls low", 1'b0, sda_oe_b_o);
    rst_pad_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("abort release", 1'b1, sda_oe_b_o);
    rst_pad_i = 1'b1;
    smfe_host_inst.get_answer(cap, seen);
    check("answer start", 1'b1, seen);
    check("answer frames", frames(T_ATR), cap);
    smfe_host_inst.run_r = 1'b0;
    rst_pad_drv_i = 1'b0;
    repeat (8) @(negedge clk_i);
    do_reset(4'h0);
    tw_cmd(1'b0, 4'h0, ack);
    check("strap zero ack", 1'b0, ack);
    smfe_host_inst.tw_stop();
    report_and_stop();
  end
endmodule
